// ---- nvw_pkg.sv ----
// Purpose: shared constants and types for the bytewide nvram host
// Assumes: 50 MHz system clock, one access at a time
// Notes: times are kept in their own unit, cycle counts derive from them
package nvw_pkg;

    // clock
    localparam int CLK_NS = 20;

    // pin, timer and run counter widths
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int TMR_W = 20;
    localparam int RUN_W = 4;

    // times at the upper supply range, ns
    localparam int T_CA_HI_NS = 70;
    localparam int T_CW_HI_NS = 70;
    localparam int T_WP_HI_NS = 40;
    localparam int T_PC_HI_NS = 60;
    localparam int T_ACC_HI_NS = 70;

    // times at the low supply range, ns
    localparam int T_CA_LO_NS = 80;
    localparam int T_CW_LO_NS = 80;
    localparam int T_WP_LO_NS = 50;
    localparam int T_PC_LO_NS = 65;
    localparam int T_ACC_LO_NS = 80;

    // power sequencing
    localparam int T_PU_MS = 10;
    localparam int T_PD_US = 0;

    // least time in ns to whole cycles, never below one
    function automatic int cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // derived cycle counts
    localparam int CA_CYC_HI = cyc(T_CA_HI_NS);
    localparam int CW_CYC_HI = cyc(T_CW_HI_NS);
    localparam int WP_CYC_HI = cyc(T_WP_HI_NS);
    localparam int PC_CYC_HI = cyc(T_PC_HI_NS);
    localparam int ACT_CYC_HI =
        imax(imax(CA_CYC_HI, CW_CYC_HI), cyc(T_ACC_HI_NS));
    localparam int CA_CYC_LO = cyc(T_CA_LO_NS);
    localparam int CW_CYC_LO = cyc(T_CW_LO_NS);
    localparam int WP_CYC_LO = cyc(T_WP_LO_NS);
    localparam int PC_CYC_LO = cyc(T_PC_LO_NS);
    localparam int ACT_CYC_LO =
        imax(imax(CA_CYC_LO, CW_CYC_LO), cyc(T_ACC_LO_NS));
    localparam int PWRUP_CYC = T_PU_MS * 1000000 / CLK_NS;

    // host sequencer states
    typedef enum logic [2:0] {
        NVW_ST_PWRUP = 3'h0,
        NVW_ST_IDLE = 3'h1,
        NVW_ST_WSET = 3'h2,
        NVW_ST_WACT = 3'h3,
        NVW_ST_RACT = 3'h4,
        NVW_ST_PRE = 3'h5
    } nvw_state_t;

endpackage

// ---- nvw_tmr_if.sv ----
// Purpose: load and expiry signals between sequencer and interval timer
// Assumes: one timer per sequencer
// Notes: expired is high while the loaded count has run out
`timescale 1ns/1ps
interface nvw_tmr_if;
    logic load;
    logic [nvw_pkg::TMR_W-1:0] value;
    logic expired;
    modport ctrl (output load, output value, input expired);
    modport timer (input load, input value, output expired);
endinterface

// ---- nvw_timer.sv ----
// Purpose: down counter that times the active and precharge phases of a bus access
// Assumes: load of n gives expiry n cycles after the loading edge
// Notes: count rests at zero, so a fresh timer reads as expired
`timescale 1ns/1ps
module nvw_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control from the sequencer
    nvw_tmr_if.timer tif
);
    typedef struct packed {
        logic [nvw_pkg::TMR_W-1:0] cnt;
    } nvw_tmr_state_t;

    nvw_tmr_state_t s_q;
    nvw_tmr_state_t s_d;

    // load wins, else count down to zero and hold
    always_comb begin
        s_d = s_q;
        if (tif.load) begin
            s_d.cnt = tif.value;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.expired = (s_q.cnt == '0);
endmodule

// ---- nvw_host.sv ----
// Purpose: host side sequencer driving a 32K x 8 bytewide nvram
// Assumes: pins sampled and driven on SYS_CLK, data input synchronous
// Notes: writes are chip-select timed, write strobe falls first
//
// Behaviour
// RL1: chip select fall latches address, starts write
// RL2: chip select low long enough before strobe rises
// RL3: write strobe held low for its minimum width
// RL4: chip select active time met every write
// RL5: device releases data pins soon after strobe
// RL6: output enable only gates the data buffers
// RL7: wait power-up interval before first access
// RL8: power may drop once strobe returns high
// RL9: select low with strobe high means read
// RL10: select returns high between every two accesses
`timescale 1ns/1ps
module nvw_host #(
    parameter bit LOW_SUPPLY = 1'b0,
    parameter int PWRUP_CYCLES = nvw_pkg::PWRUP_CYC
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // user request side
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [nvw_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [nvw_pkg::DATA_W-1:0] REQ_WDATA,
    output logic REQ_READY,
    // user answer side
    output logic RSP_VALID,
    output logic [nvw_pkg::DATA_W-1:0] RSP_RDATA,
    output logic PWR_SAFE,
    // memory control pins
    output logic NV_CE_N,
    output logic NV_WE_N,
    output logic NV_OE_N,
    output logic [nvw_pkg::ADDR_W-1:0] NV_ADDR,
    // memory data pins
    output logic [nvw_pkg::DATA_W-1:0] NV_DQ_O,
    output logic NV_DQ_OE_N,
    input wire logic [nvw_pkg::DATA_W-1:0] NV_DQ_I
);
    localparam int TW = nvw_pkg::TMR_W;
    localparam int RW = nvw_pkg::RUN_W;
    localparam int ACT_CYC =
        LOW_SUPPLY ? nvw_pkg::ACT_CYC_LO : nvw_pkg::ACT_CYC_HI;
    localparam int PC_CYC =
        LOW_SUPPLY ? nvw_pkg::PC_CYC_LO : nvw_pkg::PC_CYC_HI;
    localparam int CA_CYC =
        LOW_SUPPLY ? nvw_pkg::CA_CYC_LO : nvw_pkg::CA_CYC_HI;
    localparam int CW_CYC =
        LOW_SUPPLY ? nvw_pkg::CW_CYC_LO : nvw_pkg::CW_CYC_HI;
    localparam int WP_CYC =
        LOW_SUPPLY ? nvw_pkg::WP_CYC_LO : nvw_pkg::WP_CYC_HI;
    localparam logic [TW-1:0] ACT_LD = TW'(ACT_CYC - 1);
    localparam logic [TW-1:0] PC_LD = TW'(PC_CYC - 1);
    localparam logic [TW-1:0] PU_LD = TW'(PWRUP_CYCLES - 1);
    localparam logic [RW-1:0] RUN_MAX = '1;

    // refuse counts the timer or the run counters cannot hold
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << TW)) begin : g_chk_pu
        $error("power-up count does not fit the timer");
    end
    if (ACT_CYC > 2 ** RW - 1 || PC_CYC > 2 ** RW - 1) begin : g_chk_act
        $error("phase counts exceed run counter range");
    end

    typedef struct packed {
        nvw_pkg::nvw_state_t st;
        logic pwr_arm;
        logic [nvw_pkg::ADDR_W-1:0] addr;
        logic [nvw_pkg::DATA_W-1:0] wdata;
        logic [nvw_pkg::DATA_W-1:0] rdata;
        logic rsp;
        logic ready;
        logic safe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic dq_oe_n;
        logic [RW-1:0] ce_run;
        logic [RW-1:0] we_run;
        logic [RW-1:0] ce_hi_run;
        logic [TW-1:0] since_rst;
    } nvw_host_state_t;

    localparam nvw_host_state_t RST_S = '{
        st: nvw_pkg::NVW_ST_PWRUP,
        pwr_arm: 1'b0,
        addr: '0,
        wdata: '0,
        rdata: '0,
        rsp: 1'b0,
        ready: 1'b0,
        safe: 1'b1,
        ce_n: 1'b1,
        we_n: 1'b1,
        oe_n: 1'b1,
        dq_oe_n: 1'b1,
        ce_run: '0,
        we_run: '0,
        ce_hi_run: '0,
        since_rst: '0
    };

    nvw_host_state_t s_q;
    nvw_host_state_t s_d;
    nvw_tmr_if tmr_bus ();

    // phase timer
    nvw_timer u_timer (
        .clk (SYS_CLK),
        .rst (RESET),
        .tif (tmr_bus)
    );

    // sequencer next state, timer loads and pin values
    always_comb begin
        s_d = s_q;
        s_d.rsp = 1'b0;
        tmr_bus.load = 1'b0;
        tmr_bus.value = '0;
        case (s_q.st)
            nvw_pkg::NVW_ST_PWRUP: begin
                if (!s_q.pwr_arm) begin
                    tmr_bus.load = 1'b1; // [RL7]
                    tmr_bus.value = PU_LD;
                    s_d.pwr_arm = 1'b1;
                end else if (tmr_bus.expired) begin
                    s_d.st = nvw_pkg::NVW_ST_IDLE; // [RL7]
                end
            end
            nvw_pkg::NVW_ST_IDLE: begin
                if (REQ_VALID && s_q.ready) begin
                    s_d.addr = REQ_ADDR;
                    if (REQ_WRITE) begin
                        s_d.wdata = REQ_WDATA;
                        s_d.st = nvw_pkg::NVW_ST_WSET;
                    end else begin
                        tmr_bus.load = 1'b1;
                        tmr_bus.value = ACT_LD;
                        s_d.st = nvw_pkg::NVW_ST_RACT; // [RL9]
                    end
                end
            end
            nvw_pkg::NVW_ST_WSET: begin
                // strobe already low, select falls next: write begins
                tmr_bus.load = 1'b1;
                tmr_bus.value = ACT_LD;
                s_d.st = nvw_pkg::NVW_ST_WACT; // [RL1]
            end
            nvw_pkg::NVW_ST_WACT: begin
                if (tmr_bus.expired) begin
                    s_d.rsp = 1'b1;
                    tmr_bus.load = 1'b1;
                    tmr_bus.value = PC_LD;
                    s_d.st = nvw_pkg::NVW_ST_PRE; // [RL2] [RL3] [RL4]
                end
            end
            nvw_pkg::NVW_ST_RACT: begin
                if (tmr_bus.expired) begin
                    s_d.rdata = NV_DQ_I; // [RL9]
                    s_d.rsp = 1'b1;
                    tmr_bus.load = 1'b1;
                    tmr_bus.value = PC_LD;
                    s_d.st = nvw_pkg::NVW_ST_PRE;
                end
            end
            nvw_pkg::NVW_ST_PRE: begin
                if (tmr_bus.expired) begin
                    s_d.st = nvw_pkg::NVW_ST_IDLE; // [RL10]
                end
            end
            default: begin
                s_d.st = nvw_pkg::NVW_ST_IDLE;
            end
        endcase
        // pins follow the next state so they leave flip-flops
        s_d.ce_n = !(s_d.st == nvw_pkg::NVW_ST_WACT ||
                     s_d.st == nvw_pkg::NVW_ST_RACT); // [RL10]
        s_d.we_n = !(s_d.st == nvw_pkg::NVW_ST_WSET ||
                     s_d.st == nvw_pkg::NVW_ST_WACT);
        s_d.oe_n = (s_d.st != nvw_pkg::NVW_ST_RACT); // [RL6]
        s_d.dq_oe_n = s_d.we_n; // [RL5]
        s_d.ready = (s_d.st == nvw_pkg::NVW_ST_IDLE);
        s_d.safe = s_d.we_n; // [RL8]
        // run lengths of pin levels, saturating
        if (s_d.ce_n) begin
            s_d.ce_run = '0;
            s_d.ce_hi_run = (s_q.ce_hi_run == RUN_MAX) ?
                RUN_MAX : s_q.ce_hi_run + 1'b1;
        end else begin
            s_d.ce_hi_run = '0;
            s_d.ce_run = (s_q.ce_run == RUN_MAX) ?
                RUN_MAX : s_q.ce_run + 1'b1;
        end
        if (s_d.we_n) begin
            s_d.we_run = '0;
        end else begin
            s_d.we_run = (s_q.we_run == RUN_MAX) ?
                RUN_MAX : s_q.we_run + 1'b1;
        end
        if (s_q.since_rst != '1) begin
            s_d.since_rst = s_q.since_rst + 1'b1;
        end
    end

    // state register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            s_q <= RST_S;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign REQ_READY = s_q.ready;
    assign RSP_VALID = s_q.rsp;
    assign RSP_RDATA = s_q.rdata;
    assign PWR_SAFE = s_q.safe;
    assign NV_CE_N = s_q.ce_n;
    assign NV_WE_N = s_q.we_n;
    assign NV_OE_N = s_q.oe_n;
    assign NV_ADDR = s_q.addr;
    assign NV_DQ_O = s_q.wdata;
    assign NV_DQ_OE_N = s_q.dq_oe_n;

    // checks on the pin sequence
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    property p_ce_fall_wr;
        $fell(NV_CE_N) && !NV_WE_N |-> $past(!NV_WE_N);
    endproperty
    a_ce_fall_wr: assert property (p_ce_fall_wr) // [RL1]
        else $error("write began without strobe low before select");

    property p_cw_time;
        $rose(NV_WE_N) |-> $past(s_q.ce_run) >= CW_CYC;
    endproperty
    a_cw_time: assert property (p_cw_time) // [RL2]
        else $error("select low too short before strobe rise");

    property p_wp_time;
        $rose(NV_WE_N) |-> $past(s_q.we_run) >= WP_CYC;
    endproperty
    a_wp_time: assert property (p_wp_time) // [RL3]
        else $error("write strobe pulse too short");

    property p_ca_time;
        $rose(NV_CE_N) |-> $past(s_q.ce_run) >= CA_CYC;
    endproperty
    a_ca_time: assert property (p_ca_time) // [RL4]
        else $error("select active time too short");

    property p_pwrup;
        !NV_CE_N || REQ_READY |-> s_q.since_rst >= PWRUP_CYCLES;
    endproperty
    a_pwrup: assert property (p_pwrup) // [RL7]
        else $error("access before power-up interval");

    property p_safe;
        !NV_WE_N |-> !PWR_SAFE ##1 (NV_WE_N || !PWR_SAFE);
    endproperty
    a_safe: assert property (p_safe) // [RL8]
        else $error("power safe flag high during write strobe");

    property p_read_pins;
        !NV_OE_N |-> !NV_CE_N && NV_WE_N && NV_DQ_OE_N;
    endproperty
    a_read_pins: assert property (p_read_pins) // [RL9]
        else $error("read with strobe low or data driven");

    property p_pre_gap;
        $fell(NV_CE_N) |-> $past(s_q.ce_hi_run) >= PC_CYC;
    endproperty
    a_pre_gap: assert property (p_pre_gap) // [RL10]
        else $error("select high gap too short between accesses");

    // main scenarios
    c_write: cover property ($rose(NV_WE_N) ##1 NV_CE_N);
    c_read: cover property ($rose(NV_OE_N) && RSP_VALID);
    c_back: cover property (RSP_VALID ##[1:12] $fell(NV_CE_N));
endmodule

// ---- nvw_mem_model.sv ----
// Purpose: behavioural bytewide nvram facing the host sequencer
// Assumes: no clock, data bus resolved by the bench
// Notes: released data pins show the inverse of the last byte
`timescale 1ns/1ps
module nvw_mem_model #(
    parameter int ACC_NS = 70
) (
    // control pins
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [14:0] addr,
    // data pins
    input wire logic [7:0] dq,
    output logic [7:0] dq_out
);
    logic [7:0] mem [0:32767];
    logic [14:0] la;
    logic [7:0] wbuf;
    logic [7:0] last;
    logic wr;
    logic ok;
    logic drive;

    // cleared array, nothing pending
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'h00;
        end
        last = 8'h00;
        wr = 1'b0;
        ok = 1'b0;
    end

    // select fall latches address, write if strobe already low
    always @(negedge ce_n) begin
        ok = 1'b0;
        // address may launch on the same edge as select
        #1;
        la = addr;
        wr = !we_n;
        #(ACC_NS - 1);
        ok = 1'b1;
    end

    // strobe fall counts only while selected
    always @(negedge we_n) begin
        if (!ce_n) begin
            wr = 1'b1;
        end
    end

    // data follows the bus while both strobes low
    always @* begin
        if (!ce_n && !we_n) begin
            wbuf = dq;
        end
    end

    // write commits when select or strobe rises
    always @(posedge ce_n or posedge we_n) begin
        if (wr) begin
            mem[la] = wbuf;
        end
        wr = 1'b0;
    end

    // drives only in a read with output enable low
    assign drive = !ce_n && !oe_n && we_n && ok;
    always @* begin
        if (drive) begin
            last = mem[la];
        end
    end
    assign dq_out = drive ? mem[la] : ~last;
endmodule

// ---- tb_nvw_host.sv ----
// Purpose: self-checking bench for the bytewide nvram host
// Assumes: short power-up count, upper supply timing
// Notes: pin timing watched on falling edges, data against a map
`timescale 1ns/1ps
module tb_nvw_host;
    localparam int PWR = 20;
    localparam int ACT = nvw_pkg::ACT_CYC_HI;
    logic sys_clk;
    logic reset;
    logic req_valid;
    logic req_write;
    logic [14:0] req_addr;
    logic [7:0] req_wdata;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    logic pwr_safe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [14:0] nv_addr;
    logic [7:0] dq_o;
    logic dq_oe_n;
    logic [7:0] mem_dq;
    logic [7:0] dq_bus;
    logic [14:0] cur_addr;
    logic cur_w;
    logic ce_p;
    logic we_p;
    logic first;
    int since;
    int ce_lo;
    int ce_hi;
    int we_lo;
    int err_count;
    int checks;
    int seed;
    logic [7:0] ref_mem [int];

    // the bus carries whichever side drives, turning after the strobes
    assign #1 dq_bus = !dq_oe_n ? dq_o : mem_dq;

    nvw_host #(.LOW_SUPPLY(1'b0), .PWRUP_CYCLES(PWR)) u_nvw_host (
        .SYS_CLK(sys_clk), .RESET(reset), .REQ_VALID(req_valid),
        .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .PWR_SAFE(pwr_safe), .NV_CE_N(ce_n), .NV_WE_N(we_n),
        .NV_OE_N(oe_n), .NV_ADDR(nv_addr), .NV_DQ_O(dq_o),
        .NV_DQ_OE_N(dq_oe_n), .NV_DQ_I(dq_bus)
    );

    nvw_mem_model #(.ACC_NS(75)) u_nvw_mem_model (
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(nv_addr),
        .dq(dq_bus), .dq_out(mem_dq)
    );

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic hang;
        err_count++;
        print_verdict();
    endtask

    task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ge(input int got, input int lim);
        checks++;
        if (got < lim) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h min=%h", $time, got, lim);
        end
    endtask

    // one request, held until taken, then answer and latency checked
    task automatic access(input logic w, input logic [14:0] a,
                          input logic [7:0] d);
        int n;
        logic [7:0] exp;
        n = 0;
        @(negedge sys_clk);
        cur_addr = a;
        cur_w = w;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 100) hang();
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 20) hang();
        end
        exp = ref_mem.exists(a) ? ref_mem[a] : 8'h00;
        if (w) ref_mem[a] = d;
        chk_eq(16'(n), w ? 16'(ACT + 1) : 16'(ACT));
        if (!w) chk_eq({8'h00, rsp_rdata}, {8'h00, exp});
    endtask

    // pin timing watcher, sampled on falling edges
    always @(negedge sys_clk) begin
        if (reset) begin
            first = 1'b1;
            since = 0;
            ce_lo = 0;
            ce_hi = 0;
            we_lo = 0;
            ce_p = 1'b1;
            we_p = 1'b1;
        end else begin
            since++;
            chk_eq({15'h0000, pwr_safe}, {15'h0000, we_n});
            if (!ce_n && ce_p) begin
                chk_eq({1'b0, nv_addr}, {1'b0, cur_addr});
                chk_eq({15'h0000, we_n}, {15'h0000, !cur_w});
                chk_eq({15'h0000, oe_n}, {15'h0000, cur_w});
                chk_eq({15'h0000, dq_oe_n}, {15'h0000, !cur_w});
                if (first) chk_ge(since, PWR);
                else chk_ge(ce_hi, nvw_pkg::PC_CYC_HI);
                first = 1'b0;
            end
            if (ce_n && !ce_p) chk_ge(ce_lo, nvw_pkg::CA_CYC_HI);
            if (we_n && !we_p) begin
                chk_ge(we_lo, nvw_pkg::WP_CYC_HI);
                chk_ge(ce_lo, nvw_pkg::CW_CYC_HI);
            end
            ce_lo = ce_n ? 0 : ce_lo + 1;
            ce_hi = ce_n ? ce_hi + 1 : 0;
            we_lo = we_n ? 0 : we_lo + 1;
            ce_p = ce_n;
            we_p = we_n;
        end
    end

    // main sequence: boundaries, random traffic, reset and retention
    initial begin
        logic [31:0] r;
        seed = 14006;
        err_count = 0;
        checks = 0;
        reset = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 15'h0000;
        req_wdata = 8'h00;
        cur_addr = 15'h0000;
        cur_w = 1'b0;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        access(1'b1, 15'h0000, 8'hA5);
        access(1'b1, 15'h7FFF, 8'h5A);
        access(1'b0, 15'h0000, 8'h00);
        access(1'b0, 15'h7FFF, 8'h00);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            access(r[8], {{12{r[3]}}, r[2:0]}, r[23:16]);
        end
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        for (int i = 0; i < 16; i++) begin
            access(1'b0, {{12{i[3]}}, i[2:0]}, 8'h00);
        end
        print_verdict();
    end
endmodule
